/* File: design/sdp_params.svh */
// Register addresses, field layout, reset values and frame size for the divider/power bank
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH

`define SDP_ADDR_W        4
`define SDP_DATA_W        18
`define SDP_FRAME_BITS    22
`define SDP_CNT_W         5
`define SDP_CNT_ONE       5'h01
`define SDP_CNT_FULL      5'h16

`define SDP_ADDR_POWER    4'h2
`define SDP_ADDR_BAND1    4'h3
`define SDP_ADDR_BAND2    4'h4

`define SDP_POWER_BIT     0
`define SDP_BAND1_W       18
`define SDP_BAND2_W       17

`define SDP_POWER_RST     1'h0
`define SDP_BAND1_RST     18'h00000
`define SDP_BAND2_RST     17'h00000
`define SDP_FRAME_RST     22'h000000

`define SDP_SYNC_W        6
// Enable bit resets to its idle high level, so no false frame end follows reset
`define SDP_SYNC_RST      6'h02
`define SDP_SYNC_SCLK     0
`define SDP_SYNC_SEN      1
`define SDP_SYNC_SERIAL_INPUT_BITS    2
`define SDP_SYNC_SHUT     3
`define SDP_SYNC_VCO1     4
`define SDP_SYNC_VCO2     5

`endif

/* File: design/sdp_pkg.sv */
// Types shared by the divider/power register bank
package sdp_pkg;
    typedef enum logic
    {
        SDP_BAND_ONE = 1'b0,
        SDP_BAND_TWO = 1'b1
    } sdp_band_e;
endpackage

/* File: design/sdp_shift.sv */
// Serial frame receiver: shifts 22 bits while enabled, hands over the frame at its end
`timescale 1ns/10ps
`include "sdp_params.svh"

module sdp_shift
(
    // Clock and reset
    input  wire logic                      core_clk_in,
    input  wire logic                      srst_in,
    // Synchronised serial lines
    input  wire logic                      sclk_in,
    input  wire logic                      serial_port_enable_n_in,
    input  wire logic                      serial_input_bits_in,
    // Completed frame
    output logic                           frame_valid_out,
    output logic [`SDP_ADDR_W-1:0]         frame_addr_out,
    output logic [`SDP_DATA_W-1:0]         frame_data_out
);
    logic                      sclk_prev_q;
    logic                      sen_prev_q;
    logic [`SDP_FRAME_BITS-1:0] shift_q;
    logic [`SDP_CNT_W-1:0]     cnt_q;
    logic                      valid_q;
    logic [`SDP_ADDR_W-1:0]    addr_q;
    logic [`SDP_DATA_W-1:0]    data_q;
    logic                      sclk_rise;
    logic                      frame_end;

    assign sclk_rise = sclk_in && !sclk_prev_q;
    assign frame_end = serial_port_enable_n_in && !sen_prev_q;

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            sclk_prev_q <= 1'b0;
            sen_prev_q  <= 1'b1;
        end
        else
        begin
            sclk_prev_q <= sclk_in;
            sen_prev_q  <= serial_port_enable_n_in;
        end
    end

    // Data bits first, MSB leading; the address is the last nibble shifted in
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            shift_q <= `SDP_FRAME_RST;
            cnt_q   <= '0;
        end
        else if (serial_port_enable_n_in)
        begin
            cnt_q <= '0;
        end
        else if (sclk_rise)
        begin
            shift_q <= {shift_q[`SDP_FRAME_BITS-2:0], serial_input_bits_in};
            if (cnt_q != `SDP_CNT_FULL)
            begin
                cnt_q <= cnt_q + `SDP_CNT_ONE;
            end
        end
    end

    // Short frames are dropped; over-long ones keep the last 22 bits
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            valid_q <= 1'b0;
            addr_q  <= '0;
            data_q  <= '0;
        end
        else
        begin
            valid_q <= frame_end && (cnt_q == `SDP_CNT_FULL);
            if (frame_end)
            begin
                addr_q <= shift_q[`SDP_ADDR_W-1:0];
                data_q <= shift_q[`SDP_FRAME_BITS-1:`SDP_ADDR_W];
            end
        end
    end

    assign frame_valid_out = valid_q;
    assign frame_addr_out  = addr_q;
    assign frame_data_out  = data_q;
endmodule

/* File: design/sdp_regs.sv */
// Write-only divider and power register bank behind the three-wire serial port
`timescale 1ns/10ps
`include "sdp_params.svh"

module sdp_regs
(
    // Clock and reset
    input  wire logic                      core_clk_in,
    input  wire logic                      srst_in,
    // Serial port from host, all asynchronous
    input  wire logic                      serial_port_enable_n_in,
    input  wire logic                      serial_clk_in,
    input  wire logic                      serial_input_bits_in,
    // Shutdown pin, active low
    input  wire logic                      shutdown_pin_n_in,
    // VCO band signals, asynchronous
    input  wire logic                      vco_band_one_in,
    input  wire logic                      vco_band_two_in,
    // Power and band state
    output logic                           synth_power_on_out,
    output logic                           ref_amp_on_out,
    output logic                           band_two_selected_out,
    output logic [`SDP_BAND1_W-1:0]        band_one_feedback_count_out,
    output logic [`SDP_BAND2_W-1:0]        band_two_feedback_count_out,
    // Routed synthesizer output
    output logic                           synth_output_out
);
    logic [`SDP_SYNC_W-1:0]    sync1_q;
    logic [`SDP_SYNC_W-1:0]    sync2_q;
    logic                      frame_valid;
    logic [`SDP_ADDR_W-1:0]    frame_addr;
    logic [`SDP_DATA_W-1:0]    frame_data;
    logic                      synth_power_on_bit_q;
    logic [`SDP_BAND1_W-1:0]   band_one_q;
    logic [`SDP_BAND2_W-1:0]   band_two_q;
    sdp_pkg::sdp_band_e        band_q;
    logic                      power_on_q;
    logic                      synth_output_q;
    logic                      shut_ok;
    logic                      wr_power;
    logic                      wr_band1;
    logic                      wr_band2;

    function automatic logic addr_hit(input logic [`SDP_ADDR_W-1:0] addr,
                                      input logic [`SDP_ADDR_W-1:0] target);
        addr_hit = frame_valid && (addr == target);
    endfunction

    // Every pin crosses two flops before anything looks at it
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            sync1_q <= `SDP_SYNC_RST;
            sync2_q <= `SDP_SYNC_RST;
        end
        else
        begin
            sync1_q <= {vco_band_two_in, vco_band_one_in, shutdown_pin_n_in,
                        serial_input_bits_in, serial_port_enable_n_in, serial_clk_in};
            sync2_q <= sync1_q;
        end
    end

    // Input only; the host owns all three lines
    sdp_shift u_shift
    (
        .core_clk_in             (core_clk_in),
        .srst_in                 (srst_in),
        .sclk_in                 (sync2_q[`SDP_SYNC_SCLK]),
        .serial_port_enable_n_in (sync2_q[`SDP_SYNC_SEN]),
        .serial_input_bits_in    (sync2_q[`SDP_SYNC_SERIAL_INPUT_BITS]),
        .frame_valid_out         (frame_valid),
        .frame_addr_out          (frame_addr),
        .frame_data_out          (frame_data)
    );

    // Reserved addresses are simply ignored here
    assign wr_power = addr_hit(frame_addr, `SDP_ADDR_POWER);
    assign wr_band1 = addr_hit(frame_addr, `SDP_ADDR_BAND1);
    assign wr_band2 = addr_hit(frame_addr, `SDP_ADDR_BAND2);
    assign shut_ok  = sync2_q[`SDP_SYNC_SHUT];

    // Only bit 0 is kept; upper bits are expected zero from the host
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            synth_power_on_bit_q <= `SDP_POWER_RST;
        end
        else if (wr_power)
        begin
            synth_power_on_bit_q <= frame_data[`SDP_POWER_BIT];
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            band_one_q <= `SDP_BAND1_RST;
            band_two_q <= `SDP_BAND2_RST;
        end
        else
        begin
            if (wr_band1)
            begin
                band_one_q <= frame_data;
            end
            if (wr_band2)
            begin
                band_two_q <= frame_data[`SDP_BAND2_W-1:0];
            end
        end
    end

    // Last divider write picks the band
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            band_q <= sdp_pkg::SDP_BAND_ONE;
        end
        else if (wr_band1)
        begin
            band_q <= sdp_pkg::SDP_BAND_ONE;
        end
        else if (wr_band2)
        begin
            band_q <= sdp_pkg::SDP_BAND_TWO;
        end
    end

    // Shutdown pin overrides the register bit
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            power_on_q <= 1'b0;
        end
        else
        begin
            power_on_q <= synth_power_on_bit_q && shut_ok;
        end
    end

    // Output is held low while powered down, so no stale band leaks out
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            synth_output_q <= 1'b0;
        end
        else if (band_q == sdp_pkg::SDP_BAND_TWO)
        begin
            synth_output_q <= sync2_q[`SDP_SYNC_VCO2] && power_on_q;
        end
        else
        begin
            synth_output_q <= sync2_q[`SDP_SYNC_VCO1] && power_on_q;
        end
    end

    assign synth_power_on_out          = power_on_q;
    assign ref_amp_on_out              = power_on_q;
    assign band_two_selected_out       = (band_q == sdp_pkg::SDP_BAND_TWO);
    assign band_one_feedback_count_out = band_one_q;
    assign band_two_feedback_count_out = band_two_q;
    assign synth_output_out            = synth_output_q;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);

    sequence power_zero_write_s;
        wr_power && !frame_data[`SDP_POWER_BIT];
    endsequence

    sequence band_two_write_s;
        wr_band2 && !wr_band1;
    endsequence

    sequence no_band_one_write_s;
        !wr_band1 [*3];
    endsequence

    power_off_write_a: assert property (power_zero_write_s |=> ##1 !synth_power_on_out)
        else $error("Power bit zero did not power down");

    power_on_hold_a: assert property ((synth_power_on_bit_q && shut_ok) |=> synth_power_on_out)
        else $error("Synthesizer not running with bit set and pin high");

    band_one_load_a: assert property (wr_band1 |=> band_one_feedback_count_out == $past(frame_data))
        else $error("Band-one divider not loaded");

    band_two_load_a: assert property (wr_band2
        |=> band_two_feedback_count_out == $past(frame_data[`SDP_BAND2_W-1:0]))
        else $error("Band-two divider not loaded");

    output_route_a: assert property (##1 synth_output_out == ($past(power_on_q)
        && (($past(band_q) == sdp_pkg::SDP_BAND_TWO) ? $past(sync2_q[`SDP_SYNC_VCO2])
                                                     : $past(sync2_q[`SDP_SYNC_VCO1]))))
        else $error("Synthesizer output not from selected band");

    shutdown_force_a: assert property (!shut_ok [*2] |-> !synth_power_on_out && !ref_amp_on_out)
        else $error("Powered while shutdown pin low");

    band_follow_a: assert property (band_two_write_s ##1 no_band_one_write_s
        |-> band_two_selected_out)
        else $error("Band two not kept after its write");

    reserved_ignore_a: assert property ((frame_valid && !wr_power && !wr_band1 && !wr_band2)
        |=> $stable(band_one_q) && $stable(band_two_q) && $stable(synth_power_on_bit_q)
            && $stable(band_q))
        else $error("Reserved address changed state");
endmodule

/* File: verification/sdp_host_model.sv */
// Host controller model driving the three-wire serial port
`timescale 1ns/10ps

module sdp_host_model
(
    // Clock
    input  wire logic core_clk_in,
    // Serial port lines
    output logic      serial_port_enable_n_out,
    output logic      serial_clk_out,
    output logic      serial_input_bits_out
);
    initial
    begin
        serial_port_enable_n_out <= 1'b1;
        serial_clk_out           <= 1'b0;
        serial_input_bits_out    <= 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask

    // Data first, MSB leading, address last; clock idles low between frames
    task automatic send_frame(input logic [3:0] addr, input logic [17:0] data);
        logic [21:0] frame;
        if (addr == 4'h1 || addr > 4'h4)
            return;
        if (addr == 4'h2)
            data[17:1] = 17'h00000;
        if (addr == 4'h4)
            data[17] = 1'b0;
        frame = {data, addr};
        serial_port_enable_n_out <= 1'b0;
        for (int i = 21; i >= 0; i--)
        begin
            gap(2);
            serial_input_bits_out <= frame[i];
            gap(2);
            serial_clk_out <= 1'b1;
            gap(4);
            serial_clk_out <= 1'b0;
        end
        gap(4);
        serial_port_enable_n_out <= 1'b1;
        // Released line must not keep showing the last bit
        serial_input_bits_out <= ~frame[0];
        gap(4);
    endtask
endmodule

/* File: verification/sdp_regs_test.sv */
// Self-checking bench for the divider and power register bank
`timescale 1ns/10ps
`include "sdp_params.svh"

module sdp_regs_test;
    logic        core_clk;
    logic        srst;
    logic        sen_n;
    logic        sclk;
    logic        serial_input_bits;
    logic        shut_n;
    logic        vco1;
    logic        vco2;
    logic        pwr_on;
    logic        ref_on;
    logic        band2_sel;
    logic        synth_out;
    logic [17:0] cnt1;
    logic [16:0] cnt2;
    int          error_cnt = 0;
    int          cmp_count = 0;

    // Main configuration lies outside this bank; its writes must leave state alone
    localparam logic [3:0] addr_main_cfg = 4'h0;

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    sdp_host_model host_u
    (
        .core_clk_in              (core_clk),
        .serial_port_enable_n_out (sen_n),
        .serial_clk_out           (sclk),
        .serial_input_bits_out    (serial_input_bits)
    );

    sdp_regs dut_u
    (
        .core_clk_in                 (core_clk),
        .srst_in                     (srst),
        .serial_port_enable_n_in     (sen_n),
        .serial_clk_in               (sclk),
        .serial_input_bits_in        (serial_input_bits),
        .shutdown_pin_n_in           (shut_n),
        .vco_band_one_in             (vco1),
        .vco_band_two_in             (vco2),
        .synth_power_on_out          (pwr_on),
        .ref_amp_on_out              (ref_on),
        .band_two_selected_out       (band2_sel),
        .band_one_feedback_count_out (cnt1),
        .band_two_feedback_count_out (cnt2),
        .synth_output_out            (synth_out)
    );

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Commit takes about five clocks after the frame closes; eight is the margin
    task automatic wr(input logic [3:0] addr, input logic [17:0] data);
        host_u.send_frame(addr, data);
        repeat (8) @(posedge core_clk);
    endtask

    // Pins pass two synchronisers, the power register and the output register
    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        $display("Error at %0t ns: run timed out", $time);
        close_out();
    end

    initial
    begin
        srst <= 1'b1;
        shut_n <= 1'b1;
        vco1 <= 1'b0;
        vco2 <= 1'b1;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        settle();
        chk({14'h0000, pwr_on, ref_on, band2_sel, synth_out}, 18'h00000);
        chk(cnt1, 18'h00000);
        chk({1'b0, cnt2}, 18'h00000);
        $display("Test reset done");

        wr(`SDP_ADDR_BAND1, 18'h2a5c3);
        chk(cnt1, 18'h2a5c3);
        chk({17'h00000, band2_sel}, 18'h00000);
        wr(`SDP_ADDR_BAND2, 18'h1b7e5);
        chk({1'b0, cnt2}, 18'h1b7e5);
        chk(cnt1, 18'h2a5c3);
        chk({17'h00000, band2_sel}, 18'h00001);
        $display("Test divider writes done");

        wr(`SDP_ADDR_POWER, 18'h00001);
        chk({16'h0000, pwr_on, ref_on}, 18'h00003);
        chk({17'h00000, synth_out}, 18'h00001);
        vco2 <= 1'b0;
        vco1 <= 1'b1;
        settle();
        chk({17'h00000, synth_out}, 18'h00000);
        wr(`SDP_ADDR_BAND1, 18'h3ffff);
        chk(cnt1, 18'h3ffff);
        chk({16'h0000, band2_sel, synth_out}, 18'h00001);
        $display("Test band routing done");

        shut_n <= 1'b0;
        settle();
        chk({15'h0000, pwr_on, ref_on, synth_out}, 18'h00000);
        shut_n <= 1'b1;
        settle();
        chk({16'h0000, pwr_on, ref_on}, 18'h00003);
        wr(addr_main_cfg, 18'h00002);
        chk({16'h0000, pwr_on, band2_sel}, 18'h00002);
        chk(cnt1, 18'h3ffff);
        chk({1'b0, cnt2}, 18'h1b7e5);
        wr(`SDP_ADDR_POWER, 18'h00000);
        chk({15'h0000, pwr_on, ref_on, synth_out}, 18'h00000);
        chk({1'b0, cnt2}, 18'h1b7e5);
        $display("Test power control done");

        srst <= 1'b1;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        settle();
        chk(cnt1, 18'h00000);
        chk({1'b0, cnt2}, 18'h00000);
        chk({14'h0000, pwr_on, ref_on, band2_sel, synth_out}, 18'h00000);
        wr(`SDP_ADDR_BAND2, 18'h00155);
        chk({1'b0, cnt2}, 18'h00155);
        chk({17'h00000, band2_sel}, 18'h00001);
        $display("Test mid-run reset done");
        close_out();
    end
endmodule
